/* File: include/usbin_defs.svh */
// constants of the first non-control IN endpoint: offsets, bit positions, reset values
// assumes a 32-bit APB slave, one register to an aligned word
`ifndef USBIN_DEFS_SVH
`define USBIN_DEFS_SVH
// Overview of operation
// - endpoint registers appear only when index selects them
// - iso bit 6 clear means bulk/interrupt mode
// - interrupt on delivery, non-empty flush, or stall
// - bulk IN with packet: send, clear loaded, interrupt
// - loaded without bytes sends a zero-length packet
// - force-halt stalls bulk IN tokens, ignored in iso
// - each stall sets flag, flushes, clears loaded, interrupts
// - double buffering frees loaded bit early, no interrupt
// - force-toggle flips on each data packet sent, else only on ACK
// - iso with nothing ready: zero-length packet, underrun
// - bulk NAK sets underrun; software clears it
// - iso deferred packets wait for next SOF
// - toggle-clear write zeroes toggle, reads zero
// - flush drops one packet and self-clears
// - queue-not-empty bit shows FIFO occupancy
// - bit 7 high selects two-packet buffering

// register indexes; byte address is four times the index
`define USBIN_IDX_INDEX      8'h01
`define USBIN_IDX_IRQ_STAT   8'h02
`define USBIN_IDX_IRQ_MASK   8'h03
`define USBIN_IDX_FRAME_CFG  8'h0F
`define USBIN_IDX_CTRL_LOW   8'h11
`define USBIN_IDX_CTRL_HIGH  8'h12

// control low fields
`define USBIN_LO_LOADED      0
`define USBIN_LO_NOT_EMPTY   1
`define USBIN_LO_UNDERRUN    2
`define USBIN_LO_FLUSH       3
`define USBIN_LO_HALT        4
`define USBIN_LO_HALT_SENT   5
`define USBIN_LO_TOG_CLR     6
// control high fields
`define USBIN_HI_FORCE_TOG   3
`define USBIN_HI_ISO         6
`define USBIN_HI_DBL         7
// frame configuration field
`define USBIN_CFG_DEFER      0

`define USBIN_RST_BYTE       8'h00
`define USBIN_RST_INDEX      4'h0
`endif

/* File: include/usbin_pkg.sv */
// types shared by the IN endpoint logic
// assumes the serial bus engine consumes the answer record one cycle after a token
package usbin_pkg;
	// handshake or packet kind returned for an IN token
	typedef enum logic [1:0] {
		USBIN_NAK   = 2'b00,
		USBIN_DATA  = 2'b01,
		USBIN_STALL = 2'b10
	} usbin_kind_t;

	// answer record toward the serial bus engine
	typedef struct packed {
		logic        valid;    // one-cycle strobe
		usbin_kind_t kind;     // what to send
		logic        toggle;   // data pid toggle for a data packet
		logic        zero_len; // data packet carries no bytes
	} usbin_resp_t;
endpackage : usbin_pkg

/* File: rtl/usbin_endpoint.sv */
// IN endpoint control: APB registers, packet queue, token answers, interrupt
// assumes the serial bus engine and FIFO write path run on pclk
//
// Chosen here: the APB register port.
`include "usbin_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module usbin_endpoint
	import usbin_pkg::*;
#(
	parameter logic [3:0] EP_NUM = 4'h1  // index value that selects this endpoint
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        in_token_i,
	input  wire logic        sof_i,
	input  wire logic        host_ack_i,
	input  wire logic        fifo_byte_wr_i,
	output usbin_resp_t      resp_o,
	output logic             fifo_flush_o,
	output logic             irq_o
);

	// software state
	logic [3:0] index_r;       // endpoint selection
	logic       halt_r;        // force halt
	logic       halt_sent_r;   // stall was sent
	logic       underrun_r;    // underrun flag
	logic       loaded_r;      // packet loaded bit as read
	logic       flush_busy_r;  // flush bit while in progress
	logic       dbl_r;         // double buffering
	logic       iso_r;         // isochronous mode
	logic       ftog_r;        // force toggle
	logic       defer_r;       // deferred frame update
	logic       irq_stat_r;    // sticky endpoint event
	logic       irq_mask_r;    // event enable
	logic       toggle_r;      // data toggle
	// packet queue
	logic [1:0] ready_r;       // packets sendable now
	logic [1:0] held_r;        // packets waiting for SOF
	logic [1:0] zl_r;          // zero-length mark per queue slot, head at 0
	logic       bytes_r;       // bytes written since last commit, flush or stall
	logic [31:0] prdata_r;     // registered read data
	logic [1:0] total;         // packets held
	logic [1:0] cap;           // queue capacity

	// bus decode
	logic       wr_en;         // write takes effect
	logic [7:0] idx;           // word index of the access
	logic       ep_sel;        // endpoint registers visible
	logic       mapped;        // address is decoded
	logic       wr_lo;         // write to control low
	logic       commit;        // software loads a packet
	logic       sw_flush;      // software flush with a packet present
	logic       tog_clr;       // toggle clear request
	// token decode
	logic       tk_stall;      // answer with stall
	logic       tk_send;       // answer with a queued packet
	logic       tk_zlp;        // iso underrun zero-length answer
	logic       tk_nak;        // bulk answer with nak
	logic       ev;            // interrupt-worthy event

	// a token stalls the bus for one cycle so token and write never collide
	assign pready  = ~in_token_i;
	assign idx     = paddr[9:2];
	assign ep_sel  = (index_r == EP_NUM);
	assign wr_en   = psel & penable & pready & pwrite;
	assign total   = 2'(ready_r + held_r);
	assign cap     = dbl_r ? 2'd2 : 2'd1;

	// address decoding
	always_comb begin
		mapped = 1'b1;
		if (idx == `USBIN_IDX_INDEX) begin
			mapped = 1'b1;
		end else if (idx == `USBIN_IDX_IRQ_STAT || idx == `USBIN_IDX_IRQ_MASK) begin
			mapped = 1'b1;
		end else if (idx == `USBIN_IDX_FRAME_CFG) begin
			mapped = 1'b1;
		end else if (idx == `USBIN_IDX_CTRL_LOW || idx == `USBIN_IDX_CTRL_HIGH) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end
	assign pslverr = psel & penable & ~mapped;

	// endpoint writes only land while the index selects it
	assign wr_lo    = wr_en & ep_sel & (idx == `USBIN_IDX_CTRL_LOW);
	assign commit   = wr_lo & pwdata[`USBIN_LO_LOADED] & (total < cap);
	assign sw_flush = wr_lo & pwdata[`USBIN_LO_FLUSH] & (total != 2'd0);
	assign tog_clr  = wr_lo & pwdata[`USBIN_LO_TOG_CLR];

	// token decode; iso ignores halt, bulk and interrupt are alike
	assign tk_stall = in_token_i & ~iso_r & halt_r;
	assign tk_send  = in_token_i & ~tk_stall & (ready_r != 2'd0);
	assign tk_zlp   = in_token_i & iso_r & (ready_r == 2'd0);
	assign tk_nak   = in_token_i & ~iso_r & ~halt_r & (ready_r == 2'd0);
	assign ev       = tk_stall | tk_send | sw_flush;

	// read data latched every selected cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel) begin
			prdata_r <= 32'h0000_0000;
			if (idx == `USBIN_IDX_INDEX) begin
				prdata_r[3:0] <= index_r;
			end else if (idx == `USBIN_IDX_IRQ_STAT) begin
				prdata_r[0] <= irq_stat_r;
			end else if (idx == `USBIN_IDX_IRQ_MASK) begin
				prdata_r[0] <= irq_mask_r;
			end else if (idx == `USBIN_IDX_FRAME_CFG) begin
				prdata_r[`USBIN_CFG_DEFER] <= defer_r;
			end else if (idx == `USBIN_IDX_CTRL_LOW && ep_sel) begin
				prdata_r[`USBIN_LO_LOADED]    <= loaded_r;
				prdata_r[`USBIN_LO_NOT_EMPTY] <= (total != 2'd0);
				prdata_r[`USBIN_LO_UNDERRUN]  <= underrun_r;
				prdata_r[`USBIN_LO_FLUSH]     <= flush_busy_r;
				prdata_r[`USBIN_LO_HALT]      <= halt_r;
				prdata_r[`USBIN_LO_HALT_SENT] <= halt_sent_r;
				// toggle-clear bit always reads zero
			end else if (idx == `USBIN_IDX_CTRL_HIGH && ep_sel) begin
				prdata_r[`USBIN_HI_DBL]       <= dbl_r;
				prdata_r[`USBIN_HI_ISO]       <= iso_r;
				prdata_r[`USBIN_HI_FORCE_TOG] <= ftog_r;
			end
		end
	end
	assign prdata = prdata_r;

	// plain configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_r    <= `USBIN_RST_INDEX;
			dbl_r      <= 1'b0;
			iso_r      <= 1'b0;
			ftog_r     <= 1'b0;
			defer_r    <= 1'b0;
			irq_mask_r <= 1'b0;
			halt_r     <= 1'b0;
		end else if (wr_en) begin
			if (idx == `USBIN_IDX_INDEX) begin
				index_r <= pwdata[3:0];
			end else if (idx == `USBIN_IDX_IRQ_MASK) begin
				irq_mask_r <= pwdata[0];
			end else if (idx == `USBIN_IDX_FRAME_CFG) begin
				defer_r <= pwdata[`USBIN_CFG_DEFER];
			end else if (idx == `USBIN_IDX_CTRL_HIGH && ep_sel) begin
				dbl_r  <= pwdata[`USBIN_HI_DBL];
				iso_r  <= pwdata[`USBIN_HI_ISO];
				ftog_r <= pwdata[`USBIN_HI_FORCE_TOG];
			end else if (wr_lo) begin
				halt_r <= pwdata[`USBIN_LO_HALT];     // writing 0 ends stalls
			end
		end
	end

	// sticky flags; hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_sent_r <= 1'b0;
			underrun_r  <= 1'b0;
		end else begin
			if (tk_stall) begin
				halt_sent_r <= 1'b1;
			end else if (wr_lo) begin
				halt_sent_r <= pwdata[`USBIN_LO_HALT_SENT];
			end
			if (tk_zlp | tk_nak) begin
				underrun_r <= 1'b1;
			end else if (wr_lo) begin
				underrun_r <= pwdata[`USBIN_LO_UNDERRUN];
			end
		end
	end

	// interrupt status and level output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 1'b0;
		end else if (ev) begin
			irq_stat_r <= 1'b1;
		end else if (wr_en && idx == `USBIN_IDX_IRQ_STAT && pwdata[0]) begin
			irq_stat_r <= 1'b0;
		end
	end
	assign irq_o = irq_stat_r & irq_mask_r;

	// bytes-written tracker for zero-length packets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bytes_r <= 1'b0;
		end else if (commit | sw_flush | tk_stall) begin
			bytes_r <= 1'b0;
		end else if (fifo_byte_wr_i) begin
			bytes_r <= 1'b1;
		end
	end

	// packet queue: stall empties it, send or flush pops, commit pushes, SOF releases
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r <= 2'd0;
			held_r  <= 2'd0;
			zl_r    <= 2'b00;
		end else if (tk_stall) begin
			ready_r <= 2'd0;
			held_r  <= 2'd0;
		end else if (tk_send) begin
			ready_r <= 2'(ready_r - 2'd1);
			zl_r    <= {1'b0, zl_r[1]};
		end else if (sw_flush) begin
			zl_r <= {1'b0, zl_r[1]};
			if (ready_r != 2'd0) begin
				ready_r <= 2'(ready_r - 2'd1);
			end else begin
				held_r <= 2'(held_r - 2'd1);
			end
		end else if (commit) begin
			zl_r[total[0]] <= ~bytes_r;
			// a frame start in the same cycle still releases the older packets
			if (iso_r & defer_r) begin
				held_r  <= sof_i ? 2'd1 : 2'(held_r + 2'd1);
				ready_r <= sof_i ? total : ready_r;
			end else begin
				ready_r <= sof_i ? 2'(total + 2'd1) : 2'(ready_r + 2'd1);
				held_r  <= sof_i ? 2'd0 : held_r;
			end
		end else if (sof_i) begin
			ready_r <= total;
			held_r  <= 2'd0;
		end
	end

	// packet-loaded bit as software sees it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_r <= 1'b0;
		end else if (tk_stall | tk_send | sw_flush) begin
			loaded_r <= 1'b0;
		end else if (commit) begin
			// a free second slot or a deferred packet reads back as zero
			loaded_r <= ~(iso_r & defer_r) & ~(dbl_r & total == 2'd0);
		end else if (sof_i && held_r != 2'd0) begin
			loaded_r <= ~(dbl_r & total < 2'd2);
		end
	end

	// flush bit stays visible for the one cycle the flush takes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_busy_r <= 1'b0;
			fifo_flush_o <= 1'b0;
		end else begin
			flush_busy_r <= sw_flush;
			fifo_flush_o <= sw_flush | tk_stall;
		end
	end

	// data toggle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_r <= 1'b0;
		end else if (tog_clr) begin
			toggle_r <= 1'b0;
		end else if ((ftog_r & (tk_send | tk_zlp)) | (~ftog_r & host_ack_i)) begin
			toggle_r <= ~toggle_r;
		end
	end

	// answer record, one cycle after the token
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_o <= '0;
		end else begin
			resp_o.valid    <= in_token_i;
			resp_o.toggle   <= toggle_r;
			resp_o.zero_len <= tk_zlp | (tk_send & zl_r[0]);
			if (tk_stall) begin
				resp_o.kind <= USBIN_STALL;
			end else if (tk_send | tk_zlp) begin
				resp_o.kind <= USBIN_DATA;
			end else begin
				resp_o.kind <= USBIN_NAK;
			end
		end
	end

	// checks
	AST_STALL_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
		in_token_i && !iso_r && halt_r |=> resp_o.valid && resp_o.kind == USBIN_STALL)
		else $error("halted bulk token not stalled");
	AST_STALL_EFFECTS: assert property (@(posedge pclk) disable iff (!presetn)
		tk_stall |=> halt_sent_r && fifo_flush_o && !loaded_r && total == 2'd0 && irq_stat_r)
		else $error("stall side effects missing");
	AST_NAK_UNDERRUN: assert property (@(posedge pclk) disable iff (!presetn)
		tk_nak |=> resp_o.kind == USBIN_NAK && underrun_r)
		else $error("nak without underrun");
	AST_ISO_ZLP: assert property (@(posedge pclk) disable iff (!presetn)
		in_token_i && iso_r && ready_r == 2'd0 |=> resp_o.kind == USBIN_DATA && resp_o.zero_len && underrun_r)
		else $error("iso underrun not answered");
	AST_SEND_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
		tk_send |=> resp_o.kind == USBIN_DATA && !loaded_r && irq_stat_r && ready_r == $past(ready_r) - 2'd1)
		else $error("send did not pop the queue");
	AST_DEFER_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		held_r != 2'd0 && !sof_i && !tk_stall && !sw_flush |=> held_r != 2'd0 && !loaded_r)
		else $error("deferred packet released early");
	AST_TOG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		tog_clr |=> !toggle_r ##1 !toggle_r || $past(host_ack_i) || $past(tk_send | tk_zlp))
		else $error("toggle clear failed");
	AST_FLUSH_SELF: assert property (@(posedge pclk) disable iff (!presetn)
		sw_flush |=> flush_busy_r && fifo_flush_o && irq_stat_r ##1 !flush_busy_r || $past(sw_flush))
		else $error("flush bit did not self-clear");
	AST_DBL_EARLY: assert property (@(posedge pclk) disable iff (!presetn)
		commit && dbl_r && total == 2'd0 && !irq_stat_r |=> !loaded_r && !irq_stat_r)
		else $error("double buffer first packet not freed quietly");
	AST_FTOG: assert property (@(posedge pclk) disable iff (!presetn)
		ftog_r && tk_send && !tog_clr |=> toggle_r != $past(toggle_r))
		else $error("forced toggle not flipped");
	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		ev && irq_mask_r |=> irq_o)
		else $error("event did not raise interrupt");
	AST_SOF_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
		sof_i && held_r != 2'd0 && !commit && !sw_flush && !in_token_i |=> held_r == 2'd0 && ready_r == $past(total))
		else $error("frame start did not release deferred packets");
	AST_LOADED_QUEUED: assert property (@(posedge pclk) disable iff (!presetn)
		loaded_r |-> total != 2'd0)
		else $error("loaded bit without a queued packet");

	COV_SEND: cover property (@(posedge pclk) disable iff (!presetn) tk_send ##1 host_ack_i);
	COV_STALL: cover property (@(posedge pclk) disable iff (!presetn) tk_stall);
	COV_DEFER: cover property (@(posedge pclk) disable iff (!presetn) held_r != 2'd0 ##[1:50] sof_i);
	COV_DOUBLE: cover property (@(posedge pclk) disable iff (!presetn) total == 2'd2);
	COV_ISO_UNDERRUN: cover property (@(posedge pclk) disable iff (!presetn) tk_zlp);

endmodule : usbin_endpoint

`default_nettype wire

/* File: sim/usbin_host_model.sv */
// host-side partner: turns bench requests into IN token, SOF and ACK pulses
// assumes the endpoint answers exactly one cycle after each token
`timescale 1ns/1ps
`default_nettype none

module usbin_host_model
	import usbin_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         tok_go,     // request one IN token
	input  wire logic         sof_go,     // request one start of frame
	input  wire logic         ack_en,     // acknowledge data packets
	input  wire usbin_resp_t  resp_o,     // endpoint answer
	output logic              in_token,   // IN token pulse
	output logic              sof,        // frame start pulse
	output logic              host_ack,   // ACK after our data packet
	output usbin_resp_t       last_r      // answer to the latest token
);
	// one-cycle pulses; lines idle low between requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_token <= 1'b0;
			sof      <= 1'b0;
		end else begin
			in_token <= tok_go & ~in_token;
			sof      <= sof_go & ~sof;
		end
	end

	// a new token wipes the old answer, so a missing answer shows as invalid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r   <= '0;
			host_ack <= 1'b0;
		end else begin
			host_ack <= resp_o.valid & ack_en & (resp_o.kind == USBIN_DATA);
			if (in_token) begin
				last_r <= '0;
			end else if (resp_o.valid) begin
				last_r <= resp_o;
			end
		end
	end
endmodule : usbin_host_model

`default_nettype wire

/* File: sim/usbin_endpoint_bench.sv */
// self-checking bench for the IN endpoint: APB tasks plus host model
// assumes the design package and constants header are compiled first
`include "usbin_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module usbin_endpoint_bench;
	import usbin_pkg::*;
	localparam logic [31:0] A_IDX = 32'({`USBIN_IDX_INDEX, 2'b00});
	localparam logic [31:0] A_IRQ = 32'({`USBIN_IDX_IRQ_STAT, 2'b00});
	localparam logic [31:0] A_MSK = 32'({`USBIN_IDX_IRQ_MASK, 2'b00});
	localparam logic [31:0] A_CFG = 32'({`USBIN_IDX_FRAME_CFG, 2'b00});
	localparam logic [31:0] A_LO  = 32'({`USBIN_IDX_CTRL_LOW, 2'b00});
	localparam logic [31:0] A_HI  = 32'({`USBIN_IDX_CTRL_HIGH, 2'b00});
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        in_token, sof, host_ack, fifo_byte_wr_i, fifo_flush_o, irq_o;
	logic        tok_go, sof_go, ack_en, err;
	usbin_resp_t resp_o, last_r;
	int          fails, compares, flushes, f0;

	usbin_endpoint u_usbin_endpoint (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .in_token_i(in_token),
		.sof_i(sof), .host_ack_i(host_ack), .fifo_byte_wr_i(fifo_byte_wr_i),
		.resp_o(resp_o), .fifo_flush_o(fifo_flush_o), .irq_o(irq_o));
	usbin_host_model u_usbin_host_model (.pclk(pclk), .presetn(presetn), .tok_go(tok_go),
		.sof_go(sof_go), .ack_en(ack_en), .resp_o(resp_o), .in_token(in_token),
		.sof(sof), .host_ack(host_ack), .last_r(last_r));

	// clock and flush pulse counter
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		if (fifo_flush_o === 1'b1) flushes++;
	end

	// compare seen against expected
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// one APB transfer; waits for pready, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// let outputs launched at the completing edge settle before any compare
		@(negedge pclk);
	endtask : apb

	// read a register and compare the word
	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask : rchk

	// n byte strobes into the endpoint FIFO
	task automatic bytes(input int n);
		repeat (n) begin
			@(posedge pclk);
			fifo_byte_wr_i <= 1'b1;
			@(posedge pclk);
			fifo_byte_wr_i <= 1'b0;
		end
	endtask : bytes

	// one IN token, optionally acknowledged, then let the answer settle
	task automatic tok(input logic a);
		@(posedge pclk);
		tok_go <= 1'b1;
		ack_en <= a;
		@(posedge pclk);
		tok_go <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : tok

	// load a packet of n bytes, commit it, and request it
	task automatic send(input int n, input logic a);
		bytes(n);
		apb(1'b1, A_LO, 32'h0000_0001);
		tok(a);
	endtask : send

	// verdict and end of run
	task automatic final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// watchdog against a hung handshake
	initial begin
		#200000;
		fails++;
		final_report();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, fifo_byte_wr_i, tok_go, sof_go, ack_en} = '0;
		{paddr, pwdata, fails, compares, flushes} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// endpoint words ignored while index does not select us
		apb(1'b1, A_HI, 32'h0000_0080);
		apb(1'b1, A_IDX, 32'h0000_0001);
		rchk(A_HI, 32'h0000_0000);
		rchk(A_LO, 32'h0000_0000);
		apb(1'b0, 32'h0000_0080, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		// first packet with interrupt masked
		bytes(3);
		apb(1'b1, A_LO, 32'h0000_0001);
		rchk(A_LO, 32'h0000_0003);
		tok(1'b1);
		chk(32'(last_r), 32'h0000_0014);
		rchk(A_LO, 32'h0000_0000);
		chk(32'(irq_o), 32'h0000_0000);
		rchk(A_IRQ, 32'h0000_0001);
		apb(1'b1, A_MSK, 32'h0000_0001);
		chk(32'(irq_o), 32'h0000_0001);
		apb(1'b1, A_IRQ, 32'h0000_0001);
		chk(32'(irq_o), 32'h0000_0000);
		// zero length, toggle held without ACK, then forced toggling
		send(0, 1'b0);
		chk(32'(last_r), 32'h0000_0017);
		send(2, 1'b0);
		chk(32'(last_r), 32'h0000_0016);
		apb(1'b1, A_HI, 32'h0000_0008);
		send(1, 1'b0);
		chk(32'(last_r), 32'h0000_0016);
		send(1, 1'b0);
		chk(32'(last_r), 32'h0000_0014);
		apb(1'b1, A_HI, 32'h0000_0000);
		apb(1'b1, A_LO, 32'h0000_0040);
		rchk(A_LO, 32'h0000_0000);
		send(1, 1'b1);
		chk(32'(last_r), 32'h0000_0014);
		apb(1'b1, A_IRQ, 32'h0000_0001);
		// nothing loaded: NAK and underrun, no interrupt
		tok(1'b0);
		chk(32'(last_r[4:2]), 32'h0000_0004);
		rchk(A_LO, 32'h0000_0004);
		chk(32'(irq_o), 32'h0000_0000);
		apb(1'b1, A_LO, 32'h0000_0000);
		// halt: stall, flag, flush, interrupt
		f0 = flushes;
		apb(1'b1, A_LO, 32'h0000_0010);
		tok(1'b0);
		chk(32'(last_r[4:2]), 32'h0000_0006);
		rchk(A_LO, 32'h0000_0030);
		chk(32'(flushes), 32'(f0 + 1));
		chk(32'(irq_o), 32'h0000_0001);
		apb(1'b1, A_LO, 32'h0000_0000);
		apb(1'b1, A_IRQ, 32'h0000_0001);
		tok(1'b0);
		chk(32'(last_r[4:2]), 32'h0000_0004);
		apb(1'b1, A_LO, 32'h0000_0000);
		// flush one held packet
		bytes(2);
		apb(1'b1, A_LO, 32'h0000_0001);
		f0 = flushes;
		apb(1'b1, A_LO, 32'h0000_0008);
		rchk(A_LO, 32'h0000_0000);
		chk(32'(flushes), 32'(f0 + 1));
		chk(32'(irq_o), 32'h0000_0001);
		apb(1'b1, A_IRQ, 32'h0000_0001);
		// double buffering: first commit frees the loaded bit at once
		apb(1'b1, A_HI, 32'h0000_0080);
		bytes(2);
		apb(1'b1, A_LO, 32'h0000_0001);
		rchk(A_LO, 32'h0000_0002);
		chk(32'(irq_o), 32'h0000_0000);
		bytes(2);
		apb(1'b1, A_LO, 32'h0000_0001);
		rchk(A_LO, 32'h0000_0003);
		tok(1'b1);
		chk(32'(last_r[4:2]), 32'h0000_0005);
		chk(32'(irq_o), 32'h0000_0001);
		tok(1'b1);
		chk(32'(last_r[4:2]), 32'h0000_0005);
		rchk(A_LO, 32'h0000_0000);
		apb(1'b1, A_IRQ, 32'h0000_0001);
		// isochronous, double buffered as firmware should
		apb(1'b1, A_HI, 32'h0000_00C0);
		tok(1'b0);
		chk(32'({last_r[4:2], last_r[0]}), 32'h0000_000B);
		rchk(A_LO, 32'h0000_0004);
		apb(1'b1, A_LO, 32'h0000_0010);
		tok(1'b0);
		chk(32'(last_r[4:2]), 32'h0000_0005);
		rchk(A_LO, 32'h0000_0014);
		apb(1'b1, A_LO, 32'h0000_0000);
		// deferred update: packet waits for the next frame start
		apb(1'b1, A_HI, 32'h0000_0040);
		apb(1'b1, A_CFG, 32'h0000_0001);
		bytes(3);
		apb(1'b1, A_LO, 32'h0000_0001);
		apb(1'b0, A_LO, 32'h0000_0000);
		chk(32'(rd[0]), 32'h0000_0000);
		tok(1'b0);
		chk(32'({last_r[4:2], last_r[0]}), 32'h0000_000B);
		@(posedge pclk);
		sof_go <= 1'b1;
		@(posedge pclk);
		sof_go <= 1'b0;
		apb(1'b0, A_LO, 32'h0000_0000);
		chk(32'(rd[0]), 32'h0000_0001);
		tok(1'b1);
		chk(32'({last_r[4:2], last_r[0]}), 32'h0000_000A);
		final_report();
	end
endmodule : usbin_endpoint_bench

`default_nettype wire
